/* File: src/sbs_flag.sv */
// sticky write-one-to-clear event flags, set beats clear
`timescale 1ns/1ps
module sbs_flag #(
   parameter int N = 1
) (
   input  wire logic         i_clk_sys, // system clock
   input  wire logic         i_rst_b,   // sync reset, active low
   input  wire logic [N-1:0] i_set,     // one-cycle set events
   input  wire logic [N-1:0] i_clr,     // one-cycle clear requests
   output logic      [N-1:0] o_flag     // sticky flags
);
   typedef struct packed
   {
      logic [N-1:0] flag;
   } sbs_flag_t;
   sbs_flag_t st;
   sbs_flag_t next_st;

   // set wins over clear in the same cycle
   always_comb
   begin
      next_st.flag = i_set | (st.flag & ~i_clr);
   end

   // register the flags
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_b)
         st <= '0;
      else
         st <= next_st;
   end

   assign o_flag = st.flag;
endmodule

/* File: src/sbs_pkg.sv */
// constants for the serial bus status register block
package sbs_pkg;
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] STATUS_OFFSET = 12'hac8;
   localparam logic [11:0] CTRL_OFFSET   = 12'hacc;
   localparam int          TGT_LSB       = 1;
   localparam int          INI_LSB       = 9;
   localparam int          BLANK_BIT     = 22;
   localparam int          WRAP_BIT      = 23;
   localparam int          DONE_BIT      = 24;
   localparam int          NACK_BIT      = 25;
   localparam int          MISPL_BIT     = 27;
   localparam int          CSUM_BIT      = 28;
   localparam int          UNMAP_BIT     = 29;
   localparam int          SKIP_BIT      = 17;
   localparam logic [7:0]  DONE_CODE     = 8'hc0;
   localparam logic [6:0]  ADDR_RST      = 7'h00;
   localparam int          NFLAG         = 6;
endpackage

/* File: src/sbs_status.sv */
// serial bus status register with boot loader and bus fault flags
// Behaviour
// R1 - target port address read-only at 7:1
// R2 - initiator port address read-only at 15:9
// R3 - blank memory sets bit 22, w1c
// R4 - bad dword count also sets blank flag
// R5 - done record byte not c0 sets blank
// R6 - address wrap sets bit 23, w1c
// R7 - bit 24 set on load end or error
// R8 - unexpected nack sets bit 25, w1c
// R9 - misplaced start/stop sets bit 27, w1c
// R10 - bad checksum sets bit 28, w1c
// R11 - missing done command sets bit 28
// R12 - unmapped target sets bit 29, w1c
// R13 - skip check suppresses checksum flag
// R14 - reserved bits zero, writing zero keeps
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module sbs_status (
   input  wire logic        i_clk_sys,      // 40 MHz system clock
   input  wire logic        i_rst_b,        // sync reset, active low
   input  wire logic [11:0] i_addr,         // register byte address
   input  wire logic [31:0] i_wdata,        // write data
   input  wire logic        i_wr,           // write strobe
   input  wire logic        i_rd,           // read strobe
   output logic      [31:0] o_rdata,        // read data, cycle after rd
   input  wire logic [6:0]  i_target_port_addr,    // strap address
   input  wire logic [6:0]  i_initiator_port_addr, // strap address
   input  wire logic        i_load_enable,  // boot load mode enabled
   input  wire logic        i_blank_seen,   // loader: blank memory
   input  wire logic        i_count_bad,    // loader: bad dword count
   input  wire logic        i_done_byte_ok, // loader: done record ok
   input  wire logic [7:0]  i_done_byte,    // loader: done record byte
   input  wire logic        i_wrap_seen,    // loader: address wrapped
   input  wire logic        i_load_end,     // loader: sequence finished
   input  wire logic        i_sum_bad,      // loader: checksum mismatch
   input  wire logic        i_no_done_cmd,  // loader: no done command
   input  wire logic        i_unmapped,     // loader: unmapped target
   input  wire logic        i_nack_seen,    // master bus: unexpected nack
   input  wire logic        i_misplaced,    // master bus: bad start/stop
   output logic             o_skip_sum_check, // control bit out
   output logic             o_boot_load_complete // loader done level
);
   localparam int F_BLANK = 0;
   localparam int F_WRAP  = 1;
   localparam int F_NACK  = 2;
   localparam int F_MISPL = 3;
   localparam int F_CSUM  = 4;
   localparam int F_UNMAP = 5;

   typedef struct packed
   {
      logic [6:0]  tgt;
      logic [6:0]  ini;
      logic        done;
      logic        skip;
      logic [31:0] rdata;
   } sbs_state_t;
   sbs_state_t st;
   sbs_state_t next_st;

   logic [6:0]  tgt_s;
   logic [6:0]  ini_s;
   logic [5:0]  set_v;
   logic [5:0]  clr_v;
   logic [5:0]  flags;
   logic [31:0] status_word;
   logic        err_any;

   // address decode used by read and write
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] off);
      hit = (a == off);
   endfunction

   // strap addresses pass two flops before use
   sbs_sync #(.W(7)) u_sync_tgt (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_async   (i_target_port_addr),
      .o_sync    (tgt_s)
   );
   sbs_sync #(.W(7)) u_sync_ini (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_async   (i_initiator_port_addr),
      .o_sync    (ini_s)
   );

   // flag set events from the loader and the master bus
   always_comb
   begin
      set_v = '0;
      set_v[F_BLANK] = i_load_enable &
                       (i_blank_seen | i_count_bad                // [R3] [R4]
                        | (i_load_end & !i_done_byte_ok
                           & (i_done_byte != sbs_pkg::DONE_CODE))); // [R5]
      set_v[F_WRAP]  = i_load_enable & i_wrap_seen;               // [R6]
      set_v[F_NACK]  = i_nack_seen;                               // [R8]
      set_v[F_MISPL] = i_misplaced;                               // [R9]
      set_v[F_CSUM]  = i_load_enable &
                       ((i_sum_bad & !st.skip)                    // [R10] [R13]
                        | i_no_done_cmd);                         // [R11]
      set_v[F_UNMAP] = i_load_enable & i_unmapped;                // [R12]
   end

   // write-one clears; zero bits leave flags alone
   always_comb
   begin
      clr_v = '0;
      if (i_wr && hit(i_addr, sbs_pkg::STATUS_OFFSET))
      begin
         clr_v[F_BLANK] = i_wdata[sbs_pkg::BLANK_BIT];            // [R14]
         clr_v[F_WRAP]  = i_wdata[sbs_pkg::WRAP_BIT];
         clr_v[F_NACK]  = i_wdata[sbs_pkg::NACK_BIT];
         clr_v[F_MISPL] = i_wdata[sbs_pkg::MISPL_BIT];
         clr_v[F_CSUM]  = i_wdata[sbs_pkg::CSUM_BIT];
         clr_v[F_UNMAP] = i_wdata[sbs_pkg::UNMAP_BIT];
      end
   end

   sbs_flag #(.N(sbs_pkg::NFLAG)) u_flags (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_set     (set_v),
      .i_clr     (clr_v),
      .o_flag    (flags)
   );

   // any loader error that stops the load
   assign err_any = set_v[F_BLANK] | set_v[F_WRAP] | set_v[F_CSUM]
                    | set_v[F_UNMAP];

   // assemble the status word, reserved bits zero
   always_comb
   begin
      status_word = '0;                                           // [R14]
      status_word[sbs_pkg::TGT_LSB +: 7]  = st.tgt;               // [R1]
      status_word[sbs_pkg::INI_LSB +: 7]  = st.ini;               // [R2]
      status_word[sbs_pkg::BLANK_BIT] = flags[F_BLANK];
      status_word[sbs_pkg::WRAP_BIT]  = flags[F_WRAP];
      status_word[sbs_pkg::DONE_BIT]  = st.done;                  // [R7]
      status_word[sbs_pkg::NACK_BIT]  = flags[F_NACK];
      status_word[sbs_pkg::MISPL_BIT] = flags[F_MISPL];
      status_word[sbs_pkg::CSUM_BIT]  = flags[F_CSUM];
      status_word[sbs_pkg::UNMAP_BIT] = flags[F_UNMAP];
   end

   // next state: strap capture, done bit, control, read data
   always_comb
   begin
      next_st = st;
      // follow the synchronised straps; a one-shot capture would
      // catch the still-empty sync stages right after reset
      next_st.tgt = tgt_s;                                        // [R1]
      next_st.ini = ini_s;                                        // [R2]
      if (i_load_enable && (i_load_end || err_any))
         next_st.done = 1'b1;                                     // [R7]
      if (i_wr && hit(i_addr, sbs_pkg::CTRL_OFFSET))
         next_st.skip = i_wdata[sbs_pkg::SKIP_BIT];               // [R13]
      next_st.rdata = '0;
      if (i_rd && hit(i_addr, sbs_pkg::STATUS_OFFSET))
         next_st.rdata = status_word;
      else if (i_rd && hit(i_addr, sbs_pkg::CTRL_OFFSET))
         next_st.rdata[sbs_pkg::SKIP_BIT] = st.skip;
   end

   // single state register
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_b)
      begin
         st     <= '0;
         st.tgt <= sbs_pkg::ADDR_RST;
         st.ini <= sbs_pkg::ADDR_RST;
      end
      else
         st <= next_st;
   end

   assign o_rdata              = st.rdata;
   assign o_skip_sum_check     = st.skip;
   assign o_boot_load_complete = st.done;

   // assertions
   a_nack_sets_flag: assert property (@(posedge i_clk_sys)  // [R8]
      disable iff (!i_rst_b)
      i_nack_seen |=> flags[F_NACK])
      else $error("nack flag not set");

   a_mispl_sets_flag: assert property (@(posedge i_clk_sys) // [R9]
      disable iff (!i_rst_b)
      i_misplaced |=> flags[F_MISPL])
      else $error("misplaced flag not set");

   a_blank_sets_flag: assert property (@(posedge i_clk_sys) // [R3]
      disable iff (!i_rst_b)
      (i_load_enable && i_blank_seen) |=> flags[F_BLANK])
      else $error("blank flag not set");

   a_count_bad_flag: assert property (@(posedge i_clk_sys) // [R4]
      disable iff (!i_rst_b)
      (i_load_enable && i_count_bad) |=> flags[F_BLANK])
      else $error("count defect not shown");

   a_wrap_read_back: assert property (@(posedge i_clk_sys) // [R6]
      disable iff (!i_rst_b)
      (i_load_enable && i_wrap_seen) ##1 (i_rd && i_addr ==
         sbs_pkg::STATUS_OFFSET && !i_wr)
      |=> o_rdata[sbs_pkg::WRAP_BIT])
      else $error("wrap flag not read back");

   a_done_sticks: assert property (@(posedge i_clk_sys)  // [R7]
      disable iff (!i_rst_b)
      (i_load_enable && i_load_end) |=> o_boot_load_complete [*3])
      else $error("done bit not held");

   a_skip_masks_sum: assert property (@(posedge i_clk_sys) // [R13]
      disable iff (!i_rst_b)
      (st.skip && !flags[F_CSUM] && !i_no_done_cmd && !clr_v[F_CSUM])
      |=> !flags[F_CSUM] || $past(i_no_done_cmd))
      else $error("checksum flag set while skipped");

   a_nodone_sets: assert property (@(posedge i_clk_sys)  // [R11]
      disable iff (!i_rst_b)
      (i_load_enable && i_no_done_cmd) |=> flags[F_CSUM])
      else $error("missing done not flagged");

   a_zero_keeps: assert property (@(posedge i_clk_sys)   // [R14]
      disable iff (!i_rst_b)
      (flags[F_UNMAP] && i_wr && !i_wdata[sbs_pkg::UNMAP_BIT])
      |=> flags[F_UNMAP])
      else $error("zero write cleared flag");

   a_reserved_zero: assert property (@(posedge i_clk_sys) // [R14]
      disable iff (!i_rst_b)
      $past(i_rd && i_addr == sbs_pkg::STATUS_OFFSET) |->
      (o_rdata[0] == 1'b0 && o_rdata[8] == 1'b0 && o_rdata[26] == 1'b0))
      else $error("reserved bit nonzero");

   c_load_done: cover property (@(posedge i_clk_sys)
      disable iff (!i_rst_b) $rose(o_boot_load_complete));
   c_csum_clear: cover property (@(posedge i_clk_sys)
      disable iff (!i_rst_b) flags[F_CSUM] ##1 !flags[F_CSUM]);
   c_set_on_clear: cover property (@(posedge i_clk_sys)
      disable iff (!i_rst_b) set_v[F_NACK] && clr_v[F_NACK]);
endmodule

/* File: src/sbs_sync.sv */
// two-stage synchroniser for a bundle of pin-level inputs
`timescale 1ns/1ps
module sbs_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk_sys, // system clock
   input  wire logic         i_rst_b,   // sync reset, active low
   input  wire logic [W-1:0] i_async,   // raw levels
   output logic      [W-1:0] o_sync     // synchronised levels
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sbs_sync_t;
   sbs_sync_t st;
   sbs_sync_t next_st;

   // shift levels through two stages
   always_comb
   begin
      next_st.s1 = i_async;
      next_st.s2 = st.s1;
   end

   // register the stages
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_b)
         st <= '0;
      else
         st <= next_st;
   end

   assign o_sync = st.s2;
endmodule

/* File: tb/sbs_loader_model.sv */
// model of the loader and master bus raising one fault event at a time
`timescale 1ns/1ps
module sbs_loader_model (
   input  wire logic       i_clk_sys, // system clock
   input  wire logic       i_rst_b,   // sync reset, active low
   input  wire logic [3:0] i_code,    // event to raise
   input  wire logic       i_go,      // raise the event next cycle
   output logic      [8:0] o_ev       // one-cycle event pulses
);
   // one pulse per request, quiet otherwise
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_b)
         o_ev <= 9'h000;
      else
         o_ev <= i_go ? (9'h001 << i_code) : 9'h000;
   end
endmodule

/* File: tb/tb.sv */
// testbench for the serial bus status register
`timescale 1ns/1ps
module tb;
   logic        i_clk_sys;
   logic        i_rst_b;
   logic [11:0] i_addr;
   logic [31:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [31:0] o_rdata;
   logic        load_en;
   logic        byte_ok;
   logic [7:0]  done_byte;
   logic [3:0]  ev_code;
   logic        ev_go;
   logic [8:0]  ev;
   logic        o_skip_sum_check;
   logic        o_boot_load_complete;
   int          error_cnt;
   int          checks_done;
   localparam logic [11:0] STS  = sbs_pkg::STATUS_OFFSET;
   localparam logic [31:0] BASE = 32'h0000_66b4; // straps 33 and 5a
   localparam logic [31:0] DONE = 32'h0100_0000;
   localparam logic [31:0] RSVD = 32'hc53f_ffff;
   // event, flag raised, done expected, done record byte
   logic [3:0]  t_code [10] = '{4'h7, 4'h8, 4'h3, 4'h2, 4'h0,
                                 4'h1, 4'h3, 4'h4, 4'h5, 4'h6};
   logic [31:0] t_flag [10] = '{32'h0200_0000, 32'h0800_0000, 32'h0,
      32'h0080_0000, 32'h0040_0000, 32'h0040_0000, 32'h0040_0000,
      32'h1000_0000, 32'h1000_0000, 32'h2000_0000};
   logic        t_done [10] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
                                 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
   logic [7:0]  t_byte [10] = '{8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hc0,
                                 8'hc0, 8'h12, 8'hc0, 8'hc0, 8'hc0};

   sbs_status u_dut (
      .i_clk_sys             (i_clk_sys),
      .i_rst_b               (i_rst_b),
      .i_addr                (i_addr),
      .i_wdata               (i_wdata),
      .i_wr                  (i_wr),
      .i_rd                  (i_rd),
      .o_rdata               (o_rdata),
      .i_target_port_addr    (7'h5a),
      .i_initiator_port_addr (7'h33),
      .i_load_enable         (load_en),
      .i_blank_seen          (ev[0]),
      .i_count_bad           (ev[1]),
      .i_done_byte_ok        (byte_ok),
      .i_done_byte           (done_byte),
      .i_wrap_seen           (ev[2]),
      .i_load_end            (ev[3]),
      .i_sum_bad             (ev[4]),
      .i_no_done_cmd         (ev[5]),
      .i_unmapped            (ev[6]),
      .i_nack_seen           (ev[7]),
      .i_misplaced           (ev[8]),
      .o_skip_sum_check      (o_skip_sum_check),
      .o_boot_load_complete  (o_boot_load_complete)
   );

   sbs_loader_model u_model (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_code    (ev_code),
      .i_go      (ev_go),
      .o_ev      (ev)
   );

   // 40 MHz clock
   initial
   begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end

   task automatic tally_and_finish;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk_sys);
      i_wr    <= 1'b0;
   endtask

   // one-cycle read strobe, data checked in the following cycle
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk_sys);
      i_rd   <= 1'b0;
      #1 chk(o_rdata, e);
   endtask

   // ask the far-side model for one event pulse
   task automatic pulse(input logic [3:0] c);
      @(posedge i_clk_sys);
      ev_code <= c;
      ev_go   <= 1'b1;
      @(posedge i_clk_sys);
      ev_go   <= 1'b0;
   endtask

   // hang guard
   initial
   begin
      repeat (3000) @(posedge i_clk_sys);
      error_cnt++;
      tally_and_finish();
   end

   // main sequence
   initial
   begin
      i_rst_b = 1'b0;
      i_addr = 12'h000;
      i_wdata = 32'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      load_en = 1'b0;
      byte_ok = 1'b1;
      done_byte = 8'hc0;
      ev_code = 4'h0;
      ev_go = 1'b0;
      error_cnt = 0;
      checks_done = 0;
      repeat (3) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      rd(STS, BASE);
      rd(12'h000, 32'h0);
      pulse(4'h0);
      rd(STS, BASE);
      load_en <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         done_byte <= t_byte[i];
         byte_ok   <= (t_byte[i] == 8'hc0);
         pulse(t_code[i]);
         rd(STS, BASE | t_flag[i] | (t_done[i] ? DONE : 32'h0));
         wr(STS, 32'h0);
         rd(STS, BASE | t_flag[i] | (t_done[i] ? DONE : 32'h0));
         wr(STS, RSVD | t_flag[i]);
         rd(STS, BASE | (t_done[i] ? DONE : 32'h0));
      end
      chk({31'h0, o_boot_load_complete}, 32'h1);
      wr(sbs_pkg::CTRL_OFFSET, 32'h0002_0000);
      rd(sbs_pkg::CTRL_OFFSET, 32'h0002_0000);
      chk({31'h0, o_skip_sum_check}, 32'h1);
      pulse(4'h4);
      rd(STS, BASE | DONE);
      @(posedge i_clk_sys);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      rd(STS, BASE);
      chk({31'h0, o_boot_load_complete}, 32'h0);
      pulse(4'h2);
      rd(STS, BASE | 32'h0080_0000 | DONE);
      tally_and_finish();
   end
endmodule
